//--- logic/wfas_top.sv
/*
  auto-shutdown control of a complementary waveform generator: forces the two
  generator outputs to override levels on a software request or a fault level.
  assumes register port master on core_clk; fault and waveform inputs are async.
*/
// Added by the designer: the address map and the strobed register port.
// Notes on behaviour
// RQ1 - setting the shutdown request bit puts the generator into shutdown.
// RQ2 - without auto-restart, shutdown lasts as long as the request bit is set.
// RQ3 - with auto-restart the block clears the request bit itself and resumes on the next input rising edge.
// RQ4 - an enabled active shutdown input forces the override levels at once, with no software step.
// RQ5 - comparator, logic cell 2 and fault pin can be enabled in any combination.
// RQ6 - the source enables sit in the shutdown configuration register beside the request bit.
// RQ7 - shutdown inputs act by level, an active level holds shutdown while it lasts.
// RQ8 - shutdown does not clear while an active input persists unless its enable is cleared.
// RQ9 - leaving shutdown is either automatic or held until software clears the request bit.
`timescale 1ns/10ps
`default_nettype none
`include "wfas_consts.svh"
module wfas_top (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // register port
  input  wire logic [`WFAS_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output var  logic [7:0]              reg_rdata,
  // shutdown sources
  input  wire logic                    comparator_async_output,
  input  wire logic                    logic_cell2_output,
  input  wire logic                    fault_input_pin,
  // waveform path
  input  wire logic                    wave_in,
  input  wire logic                    gen_out_a,
  input  wire logic                    gen_out_b,
  output var  logic                    drive_a,
  output var  logic                    drive_b,
  output var  logic                    shutdown_active,
  // interrupt
  output var  logic                    irq
);

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [`WFAS_ADDR_W-1:0] a,
                               input logic [`WFAS_ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [2:0] src_sync;
  logic       wave_sync;
  logic       wave_rise;

  wfas_sync2 #(.W(3)) u_src_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({fault_input_pin, logic_cell2_output, comparator_async_output}),
    .sync_out (src_sync)
  );

  wfas_sync2 #(.W(1)) u_wave_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (wave_in),
    .sync_out (wave_sync)
  );

  wfas_edge u_wave_edge (
    .core_clk (core_clk),
    .reset    (reset),
    .level    (wave_sync),
    .rise     (wave_rise)
  );

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic [7:0]              cfg;
  logic [7:0]              ovr;
  logic [`WFAS_IRQ_W-1:0]  irq_stat;
  logic [`WFAS_IRQ_W-1:0]  irq_mask;
  logic                    src_hit;
  logic                    auto_clear;
  wfas_pkg::wfas_state_t   state;
  wfas_pkg::wfas_state_t   next_state;

  // any enabled level source, evaluated every cycle
  assign src_hit = |(src_sync & cfg[`WFAS_CFG_EN_FLT:`WFAS_CFG_EN_CMP]); // RQ5 RQ7

  // hardware clear of the request bit in auto-restart mode, once no source holds
  assign auto_clear = cfg[`WFAS_CFG_ARSEN] & (state == wfas_pkg::WFAS_SHUT) & ~src_hit; // RQ3 RQ8

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg <= `WFAS_CFG_RESET;
    end else begin
      if (reg_wr && hit(reg_addr, `WFAS_OFF_CONFIG)) begin
        cfg <= reg_wdata & `WFAS_CFG_MASK; // RQ6
      end else if (auto_clear) begin
        cfg[`WFAS_CFG_REQ] <= 1'b0; // RQ3
      end
      if (src_hit && cfg[`WFAS_CFG_ARSEN] == 1'b0) begin
        cfg[`WFAS_CFG_REQ] <= 1'b1; // RQ4 RQ9
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ovr <= `WFAS_OVR_RESET;
    end else if (reg_wr && hit(reg_addr, `WFAS_OFF_STATUS)) begin
      ovr <= reg_wdata & `WFAS_OVR_MASK;
    end
  end

  // ---------------------------------------------------------------
  // shutdown state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      wfas_pkg::WFAS_RUN: begin
        if (cfg[`WFAS_CFG_REQ] || src_hit) begin
          next_state = wfas_pkg::WFAS_SHUT; // RQ1 RQ4
        end
      end
      wfas_pkg::WFAS_SHUT: begin
        if (src_hit) begin
          next_state = wfas_pkg::WFAS_SHUT; // RQ7 RQ8
        end else if (cfg[`WFAS_CFG_ARSEN]) begin
          next_state = wfas_pkg::WFAS_WAIT_EDGE; // RQ3 RQ9
        end else if (!cfg[`WFAS_CFG_REQ]) begin
          next_state = wfas_pkg::WFAS_RUN; // RQ2 RQ9
        end
      end
      wfas_pkg::WFAS_WAIT_EDGE: begin
        if (src_hit || cfg[`WFAS_CFG_REQ]) begin
          next_state = wfas_pkg::WFAS_SHUT;
        end else if (wave_rise) begin
          next_state = wfas_pkg::WFAS_RUN; // RQ3
        end
      end
      default: next_state = wfas_pkg::WFAS_SHUT;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= wfas_pkg::WFAS_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // output override
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      drive_a         <= 1'b0;
      drive_b         <= 1'b0;
      shutdown_active <= 1'b0;
    end else if (next_state != wfas_pkg::WFAS_RUN) begin
      drive_a         <= ovr[`WFAS_OVR_A]; // RQ4
      drive_b         <= ovr[`WFAS_OVR_B]; // RQ4
      shutdown_active <= 1'b1;
    end else begin
      drive_a         <= gen_out_a;
      drive_b         <= gen_out_b;
      shutdown_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [`WFAS_IRQ_W-1:0] irq_set;
  logic [`WFAS_IRQ_W-1:0] irq_clr;

  assign irq_set[`WFAS_IRQ_ENTER]  = (state == wfas_pkg::WFAS_RUN) && (next_state == wfas_pkg::WFAS_SHUT);
  assign irq_set[`WFAS_IRQ_RESUME] = (state != wfas_pkg::WFAS_RUN) && (next_state == wfas_pkg::WFAS_RUN);
  assign irq_clr = (reg_wr && hit(reg_addr, `WFAS_OFF_IRQ_STAT)) ? reg_wdata[`WFAS_IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_mask <= '0;
    end else if (reg_wr && hit(reg_addr, `WFAS_OFF_IRQ_MASK)) begin
      irq_mask <= reg_wdata[`WFAS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (1'b1)
        hit(reg_addr, `WFAS_OFF_CONFIG):   reg_rdata <= cfg;
        hit(reg_addr, `WFAS_OFF_STATUS):   reg_rdata <= {2'b00, ovr[`WFAS_OVR_B:`WFAS_OVR_A], 1'b0, src_sync};
        hit(reg_addr, `WFAS_OFF_IRQ_STAT): reg_rdata <= {6'h00, irq_stat};
        hit(reg_addr, `WFAS_OFF_IRQ_MASK): reg_rdata <= {6'h00, irq_mask};
        default:                           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_req_enters_shut: assert property (@(posedge core_clk) disable iff (reset) // RQ1
    (state == wfas_pkg::WFAS_RUN && cfg[`WFAS_CFG_REQ]) |=> shutdown_active)
    else $error("request bit did not enter shutdown");

  chk_held_while_req: assert property (@(posedge core_clk) disable iff (reset) // RQ2
    (!cfg[`WFAS_CFG_ARSEN] && cfg[`WFAS_CFG_REQ] && state == wfas_pkg::WFAS_SHUT) |=> shutdown_active)
    else $error("shutdown left while request held");

  chk_auto_clears_req: assert property (@(posedge core_clk) disable iff (reset) // RQ3
    (auto_clear && !(reg_wr && hit(reg_addr, `WFAS_OFF_CONFIG))) |=> !cfg[`WFAS_CFG_REQ])
    else $error("auto-restart did not clear request");

  chk_resume_on_edge: assert property (@(posedge core_clk) disable iff (reset) // RQ3
    ($past(state) == wfas_pkg::WFAS_WAIT_EDGE && state == wfas_pkg::WFAS_RUN) |-> $past(wave_rise))
    else $error("resumed without rising edge");

  chk_fault_overrides: assert property (@(posedge core_clk) disable iff (reset) // RQ4
    src_hit |=> (shutdown_active && drive_a == ovr[`WFAS_OVR_A] && drive_b == ovr[`WFAS_OVR_B]))
    else $error("fault did not force override levels");

  chk_level_holds: assert property (@(posedge core_clk) disable iff (reset) // RQ7
    (src_hit [*2]) |-> state == wfas_pkg::WFAS_SHUT)
    else $error("active level did not hold shutdown");

  chk_no_clear_in_fault: assert property (@(posedge core_clk) disable iff (reset) // RQ8
    (state == wfas_pkg::WFAS_SHUT && src_hit) |=> state == wfas_pkg::WFAS_SHUT)
    else $error("shutdown cleared under active input");

  chk_manual_exit: assert property (@(posedge core_clk) disable iff (reset) // RQ9
    (state == wfas_pkg::WFAS_SHUT && !cfg[`WFAS_CFG_ARSEN] && !cfg[`WFAS_CFG_REQ] && !src_hit)
    |=> !shutdown_active ##0 state == wfas_pkg::WFAS_RUN)
    else $error("manual exit did not return to run");

  cov_sw_shutdown:  cover property (@(posedge core_clk) disable iff (reset)
    cfg[`WFAS_CFG_REQ] ##1 state == wfas_pkg::WFAS_SHUT);
  cov_auto_restart: cover property (@(posedge core_clk) disable iff (reset)
    state == wfas_pkg::WFAS_WAIT_EDGE ##[1:50] state == wfas_pkg::WFAS_RUN);
  cov_fault_shut:   cover property (@(posedge core_clk) disable iff (reset)
    src_hit ##1 shutdown_active);

endmodule : wfas_top
`default_nettype wire

//--- common/wfas_consts.svh
/*
  constants of the waveform auto-shutdown block: register offsets, field positions, reset values.
  assumes inclusion from the design and testbench files by bare name.
*/
`ifndef WFAS_CONSTS_SVH
`define WFAS_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define WFAS_ADDR_W          4
`define WFAS_OFF_CONFIG      4'h0
`define WFAS_OFF_STATUS      4'h1
`define WFAS_OFF_IRQ_STAT    4'h2
`define WFAS_OFF_IRQ_MASK    4'h3

// ---------------------------------------------------------------
// shutdown_config_register fields
// ---------------------------------------------------------------
`define WFAS_CFG_REQ         7
`define WFAS_CFG_ARSEN       6
`define WFAS_CFG_EN_FLT      2
`define WFAS_CFG_EN_LC2      1
`define WFAS_CFG_EN_CMP      0
`define WFAS_CFG_MASK        8'hc7
`define WFAS_CFG_RESET       8'h00

// ---------------------------------------------------------------
// override levels and interrupt fields
// ---------------------------------------------------------------
`define WFAS_OVR_A           4
`define WFAS_OVR_B           5
`define WFAS_OVR_MASK        8'h30
`define WFAS_OVR_RESET       8'h00
`define WFAS_IRQ_ENTER       0
`define WFAS_IRQ_RESUME      1
`define WFAS_IRQ_W           2

`endif

//--- common/wfas_pkg.sv
/*
  types of the waveform auto-shutdown block.
  assumes wfas_consts.svh is on the include path.
*/
`default_nettype none
package wfas_pkg;
  typedef enum logic [1:0] {
    WFAS_RUN,
    WFAS_SHUT,
    WFAS_WAIT_EDGE
  } wfas_state_t;
endpackage : wfas_pkg
`default_nettype wire

//--- logic/wfas_sync2.sv
/*
  two-flop synchroniser for a group of level inputs.
  assumes inputs come from outside the core_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module wfas_sync2 #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : wfas_sync2
`default_nettype wire

//--- logic/wfas_edge.sv
/*
  rising-edge detector on a synchronised level.
  assumes the input is already in the core_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module wfas_edge (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // level in, one-cycle pulse out
  input  wire logic level,
  output var  logic rise
);
  logic last;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end

  assign rise = level & ~last;
endmodule : wfas_edge
`default_nettype wire

//--- test/wfas_far_model.sv
/*
  far-side model: the three fault sources and the input waveform.
  assumes the bench commands each level; pins lag a few ns, unrelated to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module wfas_far_model (
  // commanded levels
  input  wire logic [2:0] src_cmd,
  input  wire logic       wave_cmd,
  // pins toward the block
  output wire logic       cmp_o,
  output wire logic       lc2_o,
  output wire logic       flt_o,
  output wire logic       wave_o
);
  // a source stays active as long as it is commanded
  assign #7 cmp_o  = src_cmd[0];
  assign #7 lc2_o  = src_cmd[1];
  assign #7 flt_o  = src_cmd[2];
  assign #9 wave_o = wave_cmd;
endmodule : wfas_far_model
`default_nettype wire

//--- test/tb_top.sv
/*
  testbench of the auto-shutdown block: register port, sources, outputs, irq.
  assumes the far-side model and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wfas_consts.svh"
module tb_top;
  logic       core_clk, reset, reg_wr, reg_rd, gen_out_a, gen_out_b, ga_prev, gb_prev, rd_d, wave_cmd;
  logic       ova, ovb;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, seed, en;
  logic [2:0] src_cmd;
  logic [7:0] exp_q[$];
  wire logic [7:0] reg_rdata;
  wire logic  cmp_o, lc2_o, flt_o, wave_o, drive_a, drive_b, shutdown_active, irq;
  int         err_total, num_checks;

  wfas_top dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comparator_async_output(cmp_o),
    .logic_cell2_output(lc2_o), .fault_input_pin(flt_o), .wave_in(wave_o), .gen_out_a(gen_out_a),
    .gen_out_b(gen_out_b), .drive_a(drive_a), .drive_b(drive_b), .shutdown_active(shutdown_active),
    .irq(irq));
  wfas_far_model far (.src_cmd(src_cmd), .wave_cmd(wave_cmd), .cmp_o(cmp_o), .lc2_o(lc2_o),
    .flt_o(flt_o), .wave_o(wave_o));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // random generator outputs; previous values are what the block sampled
  always @(posedge core_clk) begin
    seed      <= lfsr(seed);
    gen_out_a <= seed[0];
    gen_out_b <= seed[3];
    ga_prev   <= gen_out_a;
    gb_prev   <= gen_out_b;
    rd_d      <= reg_rd;
  end

  // read data stand only in the cycle after the strobe
  always @(negedge core_clk) begin
    if (rd_d === 1'b1) cmp8("reg_rdata", exp_q.pop_front(), reg_rdata);
  end

  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask : cmp8

  task automatic chk_out(input logic e);
    cmp8("shutdown_active", {7'h00, e}, {7'h00, shutdown_active});
    cmp8("drive_a", {7'h00, e ? ova : ga_prev}, {7'h00, drive_a});
    cmp8("drive_b", {7'h00, e ? ovb : gb_prev}, {7'h00, drive_b});
  endtask : chk_out

  task automatic chk_irq(input logic e);
    @(posedge core_clk);
    #1 cmp8("irq", {7'h00, e}, {7'h00, irq});
  endtask : chk_irq

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // bounded wait for the shutdown level, then one settled cycle
  task automatic wait_shut(input logic e, input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (shutdown_active === e) break;
    end
    cyc(1);
    chk_out(e);
  endtask : wait_shut

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #300000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    seed = 8'h55; src_cmd = 3'h0; wave_cmd = 1'b0; gen_out_a = 1'b0; gen_out_b = 1'b0;
    ga_prev = 1'b0; gb_prev = 1'b0; rd_d = 1'b0; err_total = 0; num_checks = 0;
    ova = 1'b1; ovb = 1'b0; en = 8'h00;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(`WFAS_OFF_CONFIG, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'h5, 8'hff);
    rd(`WFAS_OFF_CONFIG, 8'h00);
    rd(`WFAS_OFF_STATUS, 8'h00);
    cyc(1);
    chk_out(1'b0);
    $display("end of test: reset values");
    wr(`WFAS_OFF_IRQ_MASK, 8'h03);
    wr(`WFAS_OFF_STATUS, 8'h10);
    wr(`WFAS_OFF_CONFIG, 8'h80);
    wait_shut(1'b1, 3);
    chk_irq(1'b1);
    cyc(10);
    chk_out(1'b1);
    wr(`WFAS_OFF_CONFIG, 8'h00);
    wait_shut(1'b0, 3);
    $display("end of test: software shutdown");
    for (int i = 0; i < 3; i++) begin
      en = 8'h01 << i;
      wr(`WFAS_OFF_CONFIG, en);
      @(posedge core_clk) src_cmd <= ~(3'h1 << i);
      cyc(6);
      chk_out(1'b0);
      @(posedge core_clk) src_cmd <= 3'h7;
      wait_shut(1'b1, 4);
      rd(`WFAS_OFF_STATUS, 8'h17);
      wr(`WFAS_OFF_CONFIG, en);
      cyc(6);
      chk_out(1'b1);
      @(posedge core_clk) src_cmd <= 3'h0;
      cyc(6);
      chk_out(1'b1);
      rd(`WFAS_OFF_CONFIG, 8'h80 | en);
      wr(`WFAS_OFF_CONFIG, en);
      wait_shut(1'b0, 4);
    end
    wr(`WFAS_OFF_STATUS, 8'h20);
    ova = 1'b0;
    ovb = 1'b1;
    @(posedge core_clk) src_cmd <= 3'h1;
    cyc(4);
    chk_out(1'b0);
    wr(`WFAS_OFF_CONFIG, 8'h01);
    wait_shut(1'b1, 3);
    @(posedge core_clk) src_cmd <= 3'h0;
    cyc(4);
    wr(`WFAS_OFF_CONFIG, 8'h00);
    wait_shut(1'b0, 4);
    $display("end of test: level sources");
    wr(`WFAS_OFF_CONFIG, 8'h44);
    @(posedge core_clk) src_cmd <= 3'h4;
    wait_shut(1'b1, 4);
    @(posedge core_clk) src_cmd <= 3'h0;
    cyc(8);
    chk_out(1'b1);
    rd(`WFAS_OFF_CONFIG, 8'h44);
    @(posedge core_clk) wave_cmd <= 1'b1;
    wait_shut(1'b0, 6);
    @(posedge core_clk) wave_cmd <= 1'b0;
    wr(`WFAS_OFF_CONFIG, 8'hc0);
    wait_shut(1'b1, 3);
    rd(`WFAS_OFF_CONFIG, 8'h40);
    cyc(4);
    chk_out(1'b1);
    @(posedge core_clk) wave_cmd <= 1'b1;
    wait_shut(1'b0, 6);
    $display("end of test: auto restart");
    rd(`WFAS_OFF_IRQ_STAT, 8'h03);
    wr(`WFAS_OFF_IRQ_STAT, 8'h03);
    chk_irq(1'b0);
    rd(`WFAS_OFF_IRQ_STAT, 8'h00);
    wr(`WFAS_OFF_IRQ_MASK, 8'h00);
    wr(`WFAS_OFF_CONFIG, 8'h80);
    wait_shut(1'b1, 3);
    chk_irq(1'b0);
    rd(`WFAS_OFF_IRQ_STAT, 8'h01);
    $display("end of test: interrupts");
    cyc(2);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
